// File: tws_top.sv
// Two-wire serial EEPROM slave, 2048 bytes in 128 pages of 16.
`timescale 1ns/1ps
`include "tws_defs.svh"

// Functional notes
// - Sample on SCL rise, shift out on fall.
// - SDA is open drain: pull low or release.
// - Protect high inhibits programming; reads unaffected.
// - Only a high protect level blocks writes.
// - 128 pages of 16 bytes, 11-bit address.
// - SDA edge with SCL high is START/STOP.
// - START restarts command parsing.
// - STOP ends command; write waits for programming.
// - Acknowledge each received byte on ninth clock.
// - Standby after reset, read STOP, programming.
// - Device byte: 1010, three bits, direction.
// - Match acknowledges; mismatch returns to standby silently.
// - Direction bit one reads, zero writes.
// - Byte write: device, word address, data, STOP.
// - STOP after data starts bounded programming; bus ignored.
// - Page write takes one to sixteen bytes.
// - Only column bits increment per data byte.
// - Over sixteen bytes, column wraps and overwrites.
// - Partial page programs only loaded bytes.
// - No acknowledge while programming; polling detects completion.
// - Counter holds last address plus one.
// - Master acks to continue, nacks then STOPs.
// - Sequential read wraps from top to zero.
// - Repeated START abandons write, reads loaded address.
module tws_top
  import tws_pkg::*;
#(
  parameter int PROG_CYCLES = `TWS_PROG_CYC
)
(
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic wp_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      standby_o
);

  // ****************************************
  // Pin sampling and bus conditions
  // ****************************************

  tws_pins_s                 pins_raw;
  tws_pins_s                 pins_s;
  logic                      scl_p_q;
  logic                      sda_p_q;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_c;
  logic                      stop_c;
  tws_state_e                state_q;
  logic [`TWS_CNT_W-1:0]     cnt_q;
  logic [7:0]                rx_q;
  logic [7:0]                tx_q;
  logic                      mack_q;
  logic [`TWS_ADDR_W-1:0]    addr_q;
  logic [7:0]                buf_q [`TWS_PAGE_BYTES];
  logic [`TWS_PAGE_BYTES-1:0] mask_q;
  logic [`TWS_PROG_W-1:0]    prog_cnt_q;
  tws_wr_s                   wr_q;
  logic [7:0]                rdata;
  logic                      sda_oe_q;
  logic                      sda_o_q;
  logic                      standby_q;
  logic                      busy;
  logic                      byte_done;
  logic                      ack_end;
  logic                      dev_ok;
  logic                      commit_ok;
  logic                      prog_done;
  logic [`TWS_COL_W-1:0]     commit_col;

  // Open drain: the pin is pulled low when the bit is zero.
  function automatic logic drive_low(input logic b);
    drive_low = ~b;
  endfunction

  assign pins_raw = {scl_i, sda_i, wp_i};

  tws_sync u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .d_i     (pins_raw),
    .q_o     (pins_s)
  );

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= pins_s.scl;
      sda_p_q <= pins_s.sda;
    end
  end

  assign scl_rise   = pins_s.scl & ~scl_p_q;
  assign scl_fall   = ~pins_s.scl & scl_p_q;
  assign start_c    = pins_s.scl & scl_p_q & sda_p_q & ~pins_s.sda;
  assign stop_c     = pins_s.scl & scl_p_q & ~sda_p_q & pins_s.sda;
  assign busy       = (state_q == ST_PROG);
  assign byte_done  = scl_fall && (cnt_q == `TWS_CNT_LAST);
  assign ack_end    = scl_fall && (cnt_q == `TWS_CNT_ACK);
  assign dev_ok     = (rx_q[7:4] == `TWS_DEV_ID);
  // Only a high level inhibits; a floating pin resolves low outside.
  assign commit_ok  = (mask_q != '0) && !pins_s.wp;
  assign prog_done  = busy && (prog_cnt_q == `TWS_PROG_W'(PROG_CYCLES - 1));
  assign commit_col = prog_cnt_q[`TWS_COL_W-1:0];

  // ****************************************
  // Command sequencing
  // ****************************************

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= `TWS_CNT_ZERO;
    end
    else if (busy)
    begin
      // The bus is ignored until programming completes.
      if (prog_done)
        state_q <= ST_IDLE;
    end
    else if (start_c)
    begin
      state_q <= ST_DEV;
      cnt_q   <= `TWS_CNT_ZERO;
    end
    else if (stop_c)
    begin
      // A protected or empty write ends straight in standby.
      state_q <= (state_q == ST_WDATA && commit_ok) ? ST_PROG : ST_IDLE;
    end
    else if (state_q != ST_IDLE)
    begin
      if (scl_rise && cnt_q != `TWS_CNT_ACK)
        cnt_q <= cnt_q + `TWS_CNT_ONE;
      if (byte_done)
      begin
        case (state_q)
          ST_DEV:   state_q <= !dev_ok ? ST_IDLE : (rx_q[0] ? ST_RDATA : ST_WADDR);
          ST_WADDR: state_q <= ST_WDATA;
          default:  state_q <= state_q;
        endcase
      end
      if (ack_end)
      begin
        cnt_q <= `TWS_CNT_ZERO;
        if (state_q == ST_RDATA && !mack_q)
          state_q <= ST_IDLE;
      end
    end
  end

  // ****************************************
  // Receive shifter and master acknowledge
  // ****************************************

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      rx_q <= '0;
    else if (!busy && state_q != ST_IDLE && scl_rise && cnt_q < `TWS_CNT_LAST)
      rx_q <= {rx_q[6:0], pins_s.sda};
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      mack_q <= 1'b0;
    else if (!busy && state_q == ST_DEV && byte_done && dev_ok && rx_q[0])
      mack_q <= 1'b1;
    else if (!busy && state_q == ST_RDATA && scl_rise && cnt_q == `TWS_CNT_LAST)
      mack_q <= ~pins_s.sda;
  end

  // ****************************************
  // Address counter
  // ****************************************

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      addr_q <= '0;
    else if (!busy && !start_c && !stop_c && byte_done)
    begin
      case (state_q)
        ST_DEV:
          if (dev_ok && !rx_q[0])
            addr_q[`TWS_ADDR_W-1:8] <= rx_q[3:1];
        ST_WADDR: addr_q[7:0] <= rx_q;
        ST_WDATA: addr_q[`TWS_COL_W-1:0] <= addr_q[`TWS_COL_W-1:0] + `TWS_COL_W'(1);
        ST_RDATA: addr_q <= addr_q + `TWS_ADDR_W'(1);
        default:  addr_q <= addr_q;
      endcase
    end
  end

  // ****************************************
  // Page buffer
  // ****************************************

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      mask_q <= '0;
    else if (busy)
    begin
      if (prog_done)
        mask_q <= '0;
    end
    else if (start_c || (stop_c && !(state_q == ST_WDATA && commit_ok)))
      mask_q <= '0;
    else if (state_q == ST_WDATA && byte_done)
      mask_q[addr_q[`TWS_COL_W-1:0]] <= 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!busy && state_q == ST_WDATA && byte_done && !start_c && !stop_c)
      buf_q[addr_q[`TWS_COL_W-1:0]] <= rx_q;
  end

  // ****************************************
  // Self-timed programming
  // ****************************************

  always_ff @(posedge mclk_i)
  begin
    if (reset_i || !busy || prog_done)
      prog_cnt_q <= '0;
    else
      prog_cnt_q <= prog_cnt_q + `TWS_PROG_W'(1);
  end

  // The first sixteen cycles copy the loaded columns into the array.
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wr_q <= '0;
    end
    else
    begin
      wr_q.en   <= busy && prog_cnt_q < `TWS_COMMIT_END && mask_q[commit_col];
      wr_q.addr <= {addr_q[`TWS_ADDR_W-1:`TWS_COL_W], commit_col};
      wr_q.data <= buf_q[commit_col];
    end
  end

  tws_array u_array (
    .mclk_i  (mclk_i),
    .wr_i    (wr_q),
    .raddr_i (addr_q),
    .rdata_o (rdata)
  );

  // ****************************************
  // SDA driver
  // ****************************************

  always_ff @(posedge mclk_i)
  begin
    if (reset_i || busy || start_c || stop_c)
    begin
      sda_oe_q <= 1'b0;
      tx_q     <= '0;
    end
    else if (scl_fall)
    begin
      if (cnt_q == `TWS_CNT_LAST)
      begin
        case (state_q)
          ST_DEV:   sda_oe_q <= dev_ok;
          ST_WADDR: sda_oe_q <= 1'b1;
          ST_WDATA: sda_oe_q <= 1'b1;
          default:  sda_oe_q <= 1'b0;
        endcase
      end
      else if (cnt_q == `TWS_CNT_ACK)
      begin
        if (state_q == ST_RDATA && mack_q)
        begin
          sda_oe_q <= drive_low(rdata[7]);
          tx_q     <= {rdata[6:0], 1'b0};
        end
        else
        begin
          sda_oe_q <= 1'b0;
        end
      end
      else if (state_q == ST_RDATA)
      begin
        sda_oe_q <= drive_low(tx_q[7]);
        tx_q     <= {tx_q[6:0], 1'b0};
      end
      else
      begin
        sda_oe_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    sda_o_q   <= 1'b0;
    standby_q <= reset_i || (state_q == ST_IDLE);
  end

  assign sda_o     = sda_o_q;
  assign sda_oe_o  = sda_oe_q;
  assign standby_o = standby_q;

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  start_restart_a: assert property (start_c && !busy |=> state_q == ST_DEV && cnt_q == '0)
    else $error("START did not restart parsing.");
  read_stop_a: assert property (stop_c && state_q == ST_RDATA |=> state_q == ST_IDLE)
    else $error("STOP after read did not enter standby.");
  read_nack_a: assert property (ack_end && state_q == ST_RDATA && !mack_q
    |=> state_q == ST_IDLE)
    else $error("Read continued after a withheld acknowledge.");
  prog_quiet_a: assert property (busy |=> !sda_oe_q)
    else $error("SDA driven during programming.");
  dev_miss_a: assert property (state_q == ST_DEV && byte_done && !dev_ok
    && !busy && !start_c && !stop_c |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("Mismatched device byte acknowledged.");
  recv_ack_a: assert property (byte_done && state_q inside {ST_WADDR, ST_WDATA}
    && !busy && !start_c && !stop_c |=> sda_oe_q ##1 sda_oe_q)
    else $error("Received byte not acknowledged.");
  wp_block_a: assert property (stop_c && state_q == ST_WDATA && pins_s.wp |=> state_q == ST_IDLE)
    else $error("Programming started while protected.");
  prog_start_a: assert property (stop_c && state_q == ST_WDATA && commit_ok |=> busy [*8])
    else $error("Programming cycle not held.");
  col_wrap_a: assert property (state_q == ST_WDATA && byte_done && !start_c && !stop_c
    |=> addr_q[10:4] == $past(addr_q[10:4]) && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1)
    else $error("Page write address left its page.");
  rd_inc_a: assert property (state_q == ST_RDATA && byte_done && !start_c && !stop_c
    |=> addr_q == $past(addr_q) + 11'h001)
    else $error("Read did not advance the address.");
  oe_edge_a: assert property ($changed(sda_oe_q) |-> $past(scl_fall || start_c || stop_c || busy))
    else $error("SDA changed away from a clock fall.");

  byte_write_c:  cover property (stop_c && state_q == ST_WDATA && commit_ok);
  seq_read_c:    cover property (state_q == ST_RDATA && ack_end && mack_q);
  dev_miss_c:    cover property (state_q == ST_DEV && byte_done && !dev_ok);
  page_wrap_c:   cover property (state_q == ST_WDATA && byte_done && mask_q == '1);

endmodule

// File: tws_defs.svh
// Constants for the two-wire EEPROM slave.
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

`define TWS_CLK_NS      40
`define TWS_TWC_NS      5000000
`define TWS_PROG_CYC    (`TWS_TWC_NS / `TWS_CLK_NS)
`define TWS_PROG_W      17
`define TWS_ADDR_W      11
`define TWS_COL_W       4
`define TWS_PAGE_BYTES  16
`define TWS_MEM_WORDS   2048
`define TWS_DEV_ID      4'ha
`define TWS_CNT_W       4
`define TWS_CNT_ZERO    4'h0
`define TWS_CNT_ONE     4'h1
`define TWS_CNT_LAST    4'h8
`define TWS_CNT_ACK     4'h9
`define TWS_COMMIT_END  17'h00010

`endif

// File: tws_pkg.sv
// Types shared by the two-wire EEPROM slave modules.
`include "tws_defs.svh"

package tws_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_PROG
  } tws_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
  } tws_pins_s;

  typedef struct packed {
    logic                   en;
    logic [`TWS_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } tws_wr_s;

endpackage

// File: tws_sync.sv
// Two-stage synchroniser for the bus and protect pins.
`timescale 1ns/1ps
`include "tws_defs.svh"

module tws_sync
  import tws_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      reset_i,
  input  wire tws_pins_s d_i,
  output tws_pins_s      q_o
);

  localparam int W = $bits(tws_pins_s);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge mclk_i)
      begin
        if (reset_i)
        begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end
        else
        begin
          meta_q[g] <= d_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign q_o = tws_pins_s'(sync_q);

endmodule

// File: tws_array.sv
// Storage array of 2048 bytes with one write port and a registered read port.
`timescale 1ns/1ps
`include "tws_defs.svh"

module tws_array
  import tws_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire tws_wr_s                wr_i,
  input  wire logic [`TWS_ADDR_W-1:0] raddr_i,
  output logic [7:0]                  rdata_o
);

  logic [7:0] mem [`TWS_MEM_WORDS];

  always_ff @(posedge mclk_i)
  begin
    if (wr_i.en)
    begin
      mem[wr_i.addr] <= wr_i.data;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    rdata_o <= mem[raddr_i];
  end

endmodule

// File: tws_master.sv
// Behavioural two-wire bus master that drives SCL and pulls SDA low.
`timescale 1ns/1ps

module tws_master
(
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);

  // ****************************************************************
  // Bus idle: SCL high, SDA released to the pull-up.
  // ****************************************************************
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // ****************************************************************
  // Framing conditions.
  // ****************************************************************
  // Releases SDA while SCL is low, raises SCL, then pulls SDA down.
  task automatic start();
    sda_oe_o = 1'b0;
    tick(3);
    scl_o = 1'b1;
    tick(3);
    sda_oe_o = 1'b1;
    tick(3);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    tick(3);
    sda_oe_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(3);
    sda_oe_o = 1'b0;
    tick(4);
  endtask

  // ****************************************************************
  // One bit: five cycles low, three cycles high, 320 ns in all.
  // ****************************************************************
  // SDA only moves in the middle of the low phase.
  task automatic bit_io(input logic b, output logic r);
    tick(3);
    sda_oe_o = ~b;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    tick(1);
    scl_o = 1'b0;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Acknowledges the byte when more data is wanted, else leaves SDA high.
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask

endmodule

// File: tb.sv
// Self-checking testbench for the two-wire EEPROM slave.
`timescale 1ns/1ps

module tb;
  import tws_pkg::*;

  localparam int PROG  = 40;
  localparam int LIMIT = 20000;

  logic       mclk;
  logic       reset;
  logic       wp;
  logic       m_scl;
  logic       m_oe;
  logic       sda_o;
  logic       sda_oe;
  logic       standby;
  logic       sda;
  logic       ack;
  logic [7:0] rbyte;
  logic [10:0] ptr;
  logic [7:0] d [0:17];
  logic [7:0] mem [0:2047];
  int         fails;
  int         compares;
  int         cycles;

  // The pull-up wins unless either side pulls the line low.
  assign sda = ~(m_oe | sda_oe);

  tws_top #(.PROG_CYCLES(PROG)) DUT (
    .mclk_i    (mclk),
    .reset_i   (reset),
    .scl_i     (m_scl),
    .sda_i     (sda),
    .wp_i      (wp),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe),
    .standby_o (standby)
  );

  tws_master M (
    .mclk_i   (mclk),
    .sda_i    (sda),
    .scl_o    (m_scl),
    .sda_oe_o (m_oe)
  );

  // ****************************************************************
  // Clock, timeout and verdict.
  // ****************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ****************************************************************
  // Bus transactions with a reference copy of the array.
  // ****************************************************************
  task automatic wr(input logic [10:0] a, input int n);
    logic [3:0] col;
    col = a[3:0];
    M.start();
    M.send({4'ha, a[10:8], 1'b0}, ack);
    check({7'h00, ack}, 8'h01);
    M.send(a[7:0], ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      M.send(d[i], ack);
      check({7'h00, ack}, 8'h01);
      if (wp == 1'b0) mem[{a[10:4], col}] = d[i];
      col = col + 4'h1;
    end
    M.stop();
  endtask

  // A dummy write loads the counter before a repeated start.
  task automatic rd(input logic [10:0] a, input logic dummy, input int n);
    if (dummy)
    begin
      M.start();
      M.send({4'ha, a[10:8], 1'b0}, ack);
      M.send(a[7:0], ack);
      ptr = a;
    end
    M.start();
    M.send({4'ha, 3'h0, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      M.recv(i < n - 1, rbyte);
      check(rbyte, mem[ptr]);
      ptr = ptr + 11'h001;
    end
    M.stop();
  endtask

  task automatic wait_idle();
    for (int k = 0; k < 200 && standby !== 1'b1; k++) @(negedge mclk);
    check({7'h00, standby}, 8'h01);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    check({7'h00, standby}, 8'h01);
    check({6'h00, sda_oe, sda_o}, 8'h00);
  endtask

  task automatic t_byte_poll();
    d[0] = 8'h3c;
    wr(11'h5a3, 1);
    check({7'h00, standby}, 8'h00);
    M.start();
    M.send({4'ha, 3'h5, 1'b0}, ack);
    check({7'h00, ack}, 8'h00);
    M.stop();
    wait_idle();
    M.start();
    M.send({4'ha, 3'h5, 1'b0}, ack);
    check({7'h00, ack}, 8'h01);
    M.stop();
    rd(11'h5a3, 1'b1, 1);
  endtask

  task automatic t_page();
    for (int i = 0; i < 18; i++) d[i] = 8'h40 + 8'(i);
    wr(11'h21e, 18);
    wait_idle();
    d[0] = 8'hc1;
    d[1] = 8'hc2;
    wr(11'h213, 2);
    wait_idle();
    rd(11'h210, 1'b1, 16);
  endtask

  task automatic t_protect();
    wp = 1'b1;
    d[0] = 8'h99;
    wr(11'h210, 1);
    M.tick(4);
    check({7'h00, standby}, 8'h01);
    rd(11'h210, 1'b1, 1);
    wp = 1'b0;
  endtask

  task automatic t_bad_id();
    M.start();
    M.send(8'hb0, ack);
    check({7'h00, ack}, 8'h00);
    M.stop();
    check({7'h00, standby}, 8'h01);
  endtask

  task automatic t_wrap();
    d[0] = 8'ha5;
    wr(11'h7ff, 1);
    wait_idle();
    d[0] = 8'h5a;
    wr(11'h000, 1);
    wait_idle();
    rd(11'h7ff, 1'b1, 1);
    M.tick(4);
    check({7'h00, standby}, 8'h01);
    rd(ptr, 1'b0, 1);
  endtask

  initial
  begin
    fails    = 0;
    compares = 0;
    cycles   = 0;
    ptr      = 11'h000;
    reset    = 1'b1;
    wp       = 1'b0;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_byte_poll();
    t_page();
    t_protect();
    t_bad_id();
    t_wrap();
    tally_and_finish();
  end

endmodule
